// ===== logic/upc_cfg.svh
// constants and timing counts for the interface mode and power control ends
// Function
// (R1) system deasserts select on low core supply
// (R2) deselect or missing I/O supply powers down
// (R3) power-down leaves every interface pin undriven
// (R4) normal operation needs both supplies and select
// (R5) five interface modes, each remaps data lines
// (R6) link selects only one mode at once
// (R7) synchronous mode is default after stable clock
// (R8) link acts on interface clock rising edge
// (R9) synchronous mode carries packets, registers, status
// (R10) reference present means interface clock is driven
// (R11) clock may stop in non-synchronous modes
// (R12) idle link holds data lines low
// (R13) nonzero transmit command starts a transfer
// (R14) one turnaround cycle after each direction change
// (R15) non-synchronous modes fix data line directions
// (R16) both select inputs needed, else power-down
// (R17) direction low unless sending or blocking
// (R18) stop while direction high drops direction
// (R19) next low carries status or read data
// (R20) reselect restarts into synchronous mode, direction high
`ifndef UPC_CFG_SVH
`define UPC_CFG_SVH

`define UPC_SYS_CLK_NS 40
`define UPC_IF_CLK_MHZ 60
`define UPC_CLK_HALF 2'h2
`define UPC_CLK_STABLE_NS 1000
`define UPC_CLK_STABLE_CYC ((`UPC_CLK_STABLE_NS + `UPC_SYS_CLK_NS - 1) / `UPC_SYS_CLK_NS)
`define UPC_TURN_CYC 1
`define UPC_MODE_SYNC 0
`define UPC_MODE_LOWPWR 1
`define UPC_MODE_SER6 2
`define UPC_MODE_SER3 3
`define UPC_MODE_UART 4
`define UPC_CMD_TYPE_HI 7
`define UPC_CMD_TYPE_LO 6
`define UPC_CMD_TRANSMIT 2'h1
`define UPC_CMD_REGWR 2'h2
`define UPC_CMD_REGRD 2'h3
`define UPC_LINESTATE_MASK 8'h03
`define UPC_IDLE_BYTE 8'h00

`endif

// ===== logic/upc_pkg.sv
// types shared by both interface ends
package upc_pkg;
   typedef enum logic [2:0] {
      UPC_M_SYNC,
      UPC_M_LOWPWR,
      UPC_M_SER6,
      UPC_M_SER3,
      UPC_M_UART
   } upc_mode_t;

   typedef enum logic [3:0] {
      PS_OFF,
      PS_START,
      PS_DOWN_TURN,
      PS_IDLE,
      PS_TX_DATA,
      PS_RD_ACK,
      PS_RD_TURN,
      PS_RD_DATA,
      PS_UP_TURN,
      PS_SEND,
      PS_LOWPWR
   } upc_phy_st_t;

   typedef enum logic [2:0] {
      LS_IDLE,
      LS_CMD,
      LS_DATA,
      LS_STOP,
      LS_RD_WAIT
   } upc_link_st_t;
endpackage : upc_pkg

// ===== logic/upc_if.sv
// interface pins between the transceiver end and the link end
interface upc_if;
   logic clk;
   logic clk_oe;
   logic dir;
   logic dir_oe;
   logic nxt;
   logic nxt_oe;
   logic [7:0] phy_d;
   logic [7:0] phy_d_oe;
   logic stp;
   logic [7:0] link_d;
   logic link_d_oe;
   logic clk_w;
   logic dir_w;
   logic nxt_w;
   logic [7:0] data_w;

   // undriven pins read low, as with weak pull-downs
   assign clk_w = clk_oe & clk;
   assign dir_w = dir_oe & dir;
   assign nxt_w = nxt_oe & nxt;
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_bus
         assign data_w[gi] = phy_d_oe[gi] ? phy_d[gi] : (link_d_oe & link_d[gi]);
      end
   endgenerate

   modport phy (output clk, clk_oe, dir, dir_oe, nxt, nxt_oe, phy_d, phy_d_oe, input stp, data_w);
   modport link (output stp, link_d, link_d_oe, input clk_w, dir_w, nxt_w, data_w);
endinterface : upc_if

// ===== logic/upc_link.sv
// link end: issues commands, receives data, status and read data
`include "upc_cfg.svh"
module upc_link import upc_pkg::*; (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic CMD_VALID,
   input wire logic [7:0] CMD_BYTE,
   input wire logic [7:0] CMD_DATA,
   input wire logic ABORT,
   input wire logic WAKE,
   output logic CMD_DONE,
   output logic RX_VALID,
   output logic [7:0] RX_DATA,
   output logic RXCMD_VALID,
   output logic [7:0] RXCMD,
   output logic REG_RD_VALID,
   output logic [7:0] REG_RD_DATA,
   upc_if.link ULPI
);
   upc_link_st_t st_r;
   logic clk_d_r;
   logic dir_d_r;
   logic stp_r;
   logic [7:0] d_r;
   logic oe_r;
   logic edge_w;
   logic turn_w;
   logic is_rd_w;

   assign edge_w = ULPI.clk_w & ~clk_d_r; // [R8]
   assign turn_w = ULPI.dir_w != dir_d_r;
   assign is_rd_w = CMD_BYTE[`UPC_CMD_TYPE_HI:`UPC_CMD_TYPE_LO] == `UPC_CMD_REGRD;
   assign ULPI.stp = stp_r;
   assign ULPI.link_d = d_r;
   assign ULPI.link_d_oe = oe_r;

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         clk_d_r <= 1'b0;
         dir_d_r <= 1'b0;
      end else begin
         clk_d_r <= ULPI.clk_w;
         if (edge_w) begin
            dir_d_r <= ULPI.dir_w;
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         st_r <= LS_IDLE;
         stp_r <= 1'b0;
         d_r <= `UPC_IDLE_BYTE;
         oe_r <= 1'b0;
         CMD_DONE <= 1'b0;
         RX_VALID <= 1'b0;
         RX_DATA <= 8'h00;
         RXCMD_VALID <= 1'b0;
         RXCMD <= 8'h00;
         REG_RD_VALID <= 1'b0;
         REG_RD_DATA <= 8'h00;
      end else begin
         CMD_DONE <= 1'b0;
         RX_VALID <= 1'b0;
         RXCMD_VALID <= 1'b0;
         REG_RD_VALID <= 1'b0;
         if (WAKE) begin
            stp_r <= 1'b1; // held high to leave a non-synchronous mode
         end else if (edge_w) begin
            stp_r <= 1'b0;
         end
         if (edge_w) begin
            if (ULPI.dir_w) begin
               oe_r <= 1'b0;
               d_r <= `UPC_IDLE_BYTE;
               if (!WAKE) begin
                  stp_r <= ABORT & ~stp_r; // [R18]
               end
               if (st_r == LS_CMD && is_rd_w) begin
                  st_r <= LS_RD_WAIT;
               end
               if (!turn_w) begin // [R14]
                  if (ULPI.nxt_w) begin // [R9]
                     RX_VALID <= 1'b1;
                     RX_DATA <= ULPI.data_w;
                  end else if (st_r == LS_RD_WAIT) begin // [R19]
                     REG_RD_VALID <= 1'b1;
                     REG_RD_DATA <= ULPI.data_w;
                     CMD_DONE <= 1'b1;
                     st_r <= LS_IDLE;
                  end else begin
                     RXCMD_VALID <= 1'b1;
                     RXCMD <= ULPI.data_w;
                  end
               end
            end else begin
               oe_r <= 1'b1;
               d_r <= `UPC_IDLE_BYTE; // [R12]
               if (!turn_w) begin // [R14]
                  case (st_r)
                     LS_IDLE: begin
                        if (CMD_VALID && CMD_BYTE != `UPC_IDLE_BYTE) begin // [R13]
                           d_r <= CMD_BYTE;
                           st_r <= LS_CMD;
                        end
                     end
                     LS_CMD: begin
                        if (!ULPI.nxt_w) begin
                           d_r <= CMD_BYTE;
                        end else if (is_rd_w) begin
                           st_r <= LS_RD_WAIT;
                        end else begin
                           d_r <= CMD_DATA;
                           st_r <= LS_DATA;
                        end
                     end
                     LS_DATA: begin
                        d_r <= CMD_DATA;
                        if (ULPI.nxt_w) begin
                           d_r <= `UPC_IDLE_BYTE;
                           stp_r <= 1'b1;
                           st_r <= LS_STOP;
                        end
                     end
                     LS_STOP: begin
                        CMD_DONE <= 1'b1;
                        st_r <= LS_IDLE;
                     end
                     LS_RD_WAIT: begin
                        st_r <= LS_RD_WAIT;
                     end
                     default: st_r <= LS_IDLE;
                  endcase
               end
            end
         end
      end
   end
endmodule : upc_link

// ===== logic/upc_phy.sv
// transceiver end: power state, interface modes and synchronous protocol
`include "upc_cfg.svh"
module upc_phy import upc_pkg::*; (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic CHIP_SEL,
   input wire logic CHIP_SEL_N,
   input wire logic VIO_OK,
   input wire logic VCORE_OK,
   input wire logic CRYSTAL_INPUT_OK,
   input wire logic [4:0] MODE_SEL,
   input wire logic RX_VALID,
   input wire logic [7:0] RX_DATA,
   input wire logic [7:0] STATUS,
   input wire logic [7:0] REG_RD_DATA,
   input wire logic [1:0] LINE_STATE,
   output logic REG_EN,
   output logic PWR_DOWN,
   output logic [2:0] MODE,
   output logic RX_TAKE,
   output logic TX_VALID,
   output logic [7:0] TX_DATA,
   output logic TX_END,
   output logic REG_WR,
   output logic REG_RD,
   output logic [5:0] REG_ADDR,
   output logic [7:0] REG_WDATA,
   upc_if.phy ULPI
);
   localparam int STABLE_CYC = `UPC_CLK_STABLE_CYC;

   upc_phy_st_t st_r;
   upc_mode_t mode_r;
   logic [3:0] pin_s1_r;
   logic [3:0] pin_s2_r;
   logic [3:0] pin_s3_r;
   logic [3:0] pin_r;
   logic [1:0] div_r;
   logic clk_r;
   logic tick_w;
   logic clk_run_w;
   logic [$clog2(STABLE_CYC + 1)-1:0] stab_r;
   logic stable_w;
   logic sel_ok_w;
   logic normal_w;
   logic [7:0] cmd_r;
   logic [7:0] last_stat_r;
   logic dir_r;
   logic nxt_r;
   logic [7:0] d_r;
   logic [7:0] d_oe_r;
   logic pins_on_r;
   logic one_hot_w;
   logic [1:0] cmd_type_w;
   logic [1:0] ls_r;
   logic [1:0] lp_wait_r;
   logic [7:0] stat_w;

   // select and supply inputs pass three flops, change once stages 2 and 3 agree
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         always_ff @(posedge SYS_CLK) begin
            if (!RST_N) begin
               pin_s1_r[gi] <= 1'b0;
               pin_s2_r[gi] <= 1'b0;
               pin_s3_r[gi] <= 1'b0;
               pin_r[gi] <= 1'b0;
            end else begin
               pin_s1_r[gi] <= (gi == 0) ? CHIP_SEL : (gi == 1) ? ~CHIP_SEL_N : (gi == 2) ? VIO_OK : VCORE_OK;
               pin_s2_r[gi] <= pin_s1_r[gi];
               pin_s3_r[gi] <= pin_s2_r[gi];
               if (pin_s2_r[gi] == pin_s3_r[gi]) begin
                  pin_r[gi] <= pin_s3_r[gi];
               end
            end
         end
      end
   endgenerate

   assign sel_ok_w = pin_r[0] & pin_r[1] & pin_r[2]; // [R16] [R2]
   assign normal_w = sel_ok_w & pin_r[3] & CRYSTAL_INPUT_OK; // [R4]
   assign one_hot_w = (MODE_SEL != 5'h00) && ((MODE_SEL & (MODE_SEL - 5'h01)) == 5'h00); // [R6]
   assign cmd_type_w = ULPI.data_w[`UPC_CMD_TYPE_HI:`UPC_CMD_TYPE_LO];
   // status byte carries the line state in its low bits
   assign stat_w = {STATUS[7:2], ls_r};

   // interface clock stops when off and in non-synchronous modes
   assign clk_run_w = (st_r != PS_OFF) && (st_r != PS_LOWPWR); // [R10] [R11]
   assign tick_w = clk_run_w && (div_r == `UPC_CLK_HALF - 2'h1) && !clk_r;

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         div_r <= 2'h0;
         clk_r <= 1'b0;
      end else if (!clk_run_w && !clk_r) begin
         div_r <= 2'h0;
         clk_r <= 1'b0;
      end else if (div_r == `UPC_CLK_HALF - 2'h1) begin
         div_r <= 2'h0;
         clk_r <= ~clk_r;
      end else begin
         div_r <= div_r + 2'h1;
      end
   end

   // clock settle time before the interface is released
   assign stable_w = stab_r == STABLE_CYC[$bits(stab_r)-1:0];
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N || st_r != PS_START) begin
         stab_r <= '0;
      end else if (!stable_w) begin
         stab_r <= stab_r + 1'b1;
      end
   end

   assign ULPI.clk = clk_r;
   assign ULPI.dir = dir_r;
   assign ULPI.nxt = nxt_r;
   assign ULPI.phy_d = d_r;
   assign ULPI.phy_d_oe = d_oe_r;
   assign ULPI.clk_oe = pins_on_r;
   assign ULPI.dir_oe = pins_on_r;
   assign ULPI.nxt_oe = pins_on_r;

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         st_r <= PS_OFF;
         mode_r <= UPC_M_SYNC;
         cmd_r <= 8'h00;
         last_stat_r <= 8'h00;
         lp_wait_r <= 2'h0;
         dir_r <= 1'b0;
         nxt_r <= 1'b0;
         d_r <= 8'h00;
         d_oe_r <= 8'h00;
         pins_on_r <= 1'b0;
         REG_EN <= 1'b0;
         PWR_DOWN <= 1'b1;
         MODE <= 3'h0;
         RX_TAKE <= 1'b0;
         TX_VALID <= 1'b0;
         TX_DATA <= 8'h00;
         TX_END <= 1'b0;
         REG_WR <= 1'b0;
         REG_RD <= 1'b0;
         REG_ADDR <= 6'h00;
         REG_WDATA <= 8'h00;
      end else begin
         RX_TAKE <= 1'b0;
         TX_VALID <= 1'b0;
         TX_END <= 1'b0;
         REG_WR <= 1'b0;
         REG_RD <= 1'b0;
         MODE <= 3'(mode_r);
         if (!normal_w) begin
            st_r <= PS_OFF; // [R2] [R1]
            mode_r <= UPC_M_SYNC;
            pins_on_r <= 1'b0; // [R3]
            d_oe_r <= 8'h00;
            dir_r <= 1'b0;
            nxt_r <= 1'b0;
            REG_EN <= 1'b0;
            PWR_DOWN <= 1'b1;
         end else if (st_r == PS_OFF) begin
            st_r <= PS_START; // [R20]
            mode_r <= UPC_M_SYNC;
            pins_on_r <= 1'b1;
            dir_r <= 1'b1; // [R17]
            REG_EN <= 1'b1;
            PWR_DOWN <= 1'b0;
         end else if (st_r == PS_LOWPWR) begin
            if (ULPI.stp) begin
               st_r <= PS_START; // [R7]
               mode_r <= UPC_M_SYNC;
               d_oe_r <= 8'h00;
            end else begin
               d_r <= {6'h00, ls_r};
               // wait until the link has released the bus
               if (lp_wait_r != 2'h3) begin
                  lp_wait_r <= lp_wait_r + 2'h1;
               end else begin
                  d_oe_r <= `UPC_LINESTATE_MASK; // [R15]
               end
            end
         end else if (tick_w) begin
            if (dir_r && ULPI.stp && st_r inside {PS_UP_TURN, PS_SEND, PS_RD_TURN, PS_RD_DATA}) begin
               dir_r <= 1'b0; // [R18]
               nxt_r <= 1'b0;
               d_oe_r <= 8'h00;
               st_r <= PS_DOWN_TURN;
            end else begin
               case (st_r)
                  PS_START: begin
                     if (stable_w) begin
                        dir_r <= 1'b0; // [R7] [R20]
                        st_r <= PS_DOWN_TURN;
                     end
                  end
                  PS_DOWN_TURN: st_r <= PS_IDLE; // [R14]
                  PS_IDLE: begin
                     if (one_hot_w && !MODE_SEL[`UPC_MODE_SYNC]) begin // [R5]
                        dir_r <= 1'b1;
                        st_r <= PS_LOWPWR;
                        lp_wait_r <= 2'h0;
                        mode_r <= MODE_SEL[`UPC_MODE_LOWPWR] ? UPC_M_LOWPWR :
                                  MODE_SEL[`UPC_MODE_SER6] ? UPC_M_SER6 :
                                  MODE_SEL[`UPC_MODE_SER3] ? UPC_M_SER3 : UPC_M_UART;
                     end else if (RX_VALID || stat_w != last_stat_r) begin
                        dir_r <= 1'b1; // [R17]
                        st_r <= PS_UP_TURN;
                     end else if (ULPI.data_w != `UPC_IDLE_BYTE) begin // [R13]
                        cmd_r <= ULPI.data_w;
                        nxt_r <= 1'b1;
                        REG_ADDR <= ULPI.data_w[5:0];
                        st_r <= (cmd_type_w == `UPC_CMD_REGRD) ? PS_RD_ACK : PS_TX_DATA;
                     end
                  end
                  PS_TX_DATA: begin
                     if (ULPI.stp) begin
                        nxt_r <= 1'b0;
                        REG_WR <= cmd_r[`UPC_CMD_TYPE_HI:`UPC_CMD_TYPE_LO] == `UPC_CMD_REGWR;
                        TX_END <= cmd_r[`UPC_CMD_TYPE_HI:`UPC_CMD_TYPE_LO] != `UPC_CMD_REGWR;
                        st_r <= PS_IDLE;
                     end else if (cmd_r[`UPC_CMD_TYPE_HI:`UPC_CMD_TYPE_LO] == `UPC_CMD_REGWR) begin
                        REG_WDATA <= ULPI.data_w; // [R9]
                     end else begin
                        TX_VALID <= 1'b1;
                        TX_DATA <= ULPI.data_w;
                     end
                  end
                  PS_RD_ACK: begin
                     nxt_r <= 1'b0;
                     dir_r <= 1'b1;
                     REG_RD <= 1'b1;
                     st_r <= PS_RD_TURN;
                  end
                  PS_RD_TURN: begin
                     d_r <= REG_RD_DATA; // [R19]
                     d_oe_r <= 8'hFF;
                     st_r <= PS_RD_DATA;
                  end
                  PS_RD_DATA: begin
                     dir_r <= 1'b0;
                     d_oe_r <= 8'h00;
                     st_r <= PS_DOWN_TURN;
                  end
                  PS_UP_TURN, PS_SEND: begin
                     d_oe_r <= 8'hFF;
                     if (RX_VALID) begin
                        d_r <= RX_DATA; // [R9]
                        nxt_r <= 1'b1;
                        RX_TAKE <= 1'b1;
                        st_r <= PS_SEND;
                     end else if (st_r == PS_UP_TURN) begin
                        d_r <= stat_w; // [R19]
                        last_stat_r <= stat_w;
                        nxt_r <= 1'b0;
                        st_r <= PS_SEND;
                     end else begin
                        dir_r <= 1'b0; // [R17]
                        nxt_r <= 1'b0;
                        d_oe_r <= 8'h00;
                        st_r <= PS_DOWN_TURN;
                     end
                  end
                  default: st_r <= PS_START;
               endcase
            end
         end
      end
   end

   // line state bits follow the receiver
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         ls_r <= 2'h0;
      end else begin
         ls_r <= LINE_STATE;
      end
   end
endmodule : upc_phy

// ===== testbench/upc_props.sv
// concurrent checks on the pins between the transceiver end and the link end
module upc_props (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic CHIP_SEL,
   input wire logic CHIP_SEL_N,
   input wire logic clk_w,
   input wire logic clk_oe,
   input wire logic dir_w,
   input wire logic dir_oe,
   input wire logic nxt_w,
   input wire logic nxt_oe,
   input wire logic [7:0] phy_d_oe,
   input wire logic link_d_oe,
   input wire logic stp,
   input wire logic [7:0] data_w
);
   logic clk_q;
   logic tick;
   logic sel_ok;

   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RST_N);

   always_ff @(posedge SYS_CLK) begin
      clk_q <= clk_w;
   end
   // first system cycle after the interface clock fell, before the next rise
   assign tick = ~clk_w & clk_q;
   assign sel_ok = CHIP_SEL & ~CHIP_SEL_N;

   sequence pins_off_s;
      !clk_oe && !dir_oe && !nxt_oe && phy_d_oe == 8'h00;
   endsequence
   sequence turn_s;
      (phy_d_oe == 8'h00) [*3];
   endsequence

   desel_off_a: assert property ($fell(sel_ok) ##1 (!sel_ok) [*8] |-> pins_off_s)
      else $error("pins still driven after deselect");
   sel_n_off_a: assert property ($rose(CHIP_SEL_N) ##1 CHIP_SEL_N [*8] |-> pins_off_s)
      else $error("pins still driven with low select input deasserted");
   no_contention_a: assert property (phy_d_oe != 8'h00 |-> !link_d_oe)
      else $error("both ends drive the data bus");
   turn_cycle_a: assert property ($rose(dir_w) |-> turn_s)
      else $error("data driven in turnaround cycle");
   bus_owner_a: assert property (!dir_w |-> phy_d_oe == 8'h00)
      else $error("transceiver drives data with direction low");
   stop_abort_a: assert property (tick && dir_w && nxt_w && stp |-> ##[1:5] !dir_w)
      else $error("direction not dropped after stop");
   cmd_next_a: assert property (tick && !dir_w && !nxt_w && !stp && link_d_oe && data_w != 8'h00 |-> ##[1:5] nxt_w)
      else $error("no next after transmit command");
   clk_half_a: assert property ($rose(clk_w) |-> ##1 (clk_w || !clk_oe) ##1 !clk_w)
      else $error("interface clock half period wrong");
endmodule : upc_props

// ===== testbench/upc_tb_top.sv
// bench joining both interface ends and driving their user sides
module upc_tb_top import upc_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk, rst_n, chip_sel, chip_sel_n, vio_ok, vcore_ok, xtal_ok;
   logic [4:0] mode_sel;
   logic p_rx_valid, cmd_valid, abort, wake;
   logic [7:0] p_rx_data, status, p_rd_data, cmd_byte, cmd_data;
   logic [1:0] line_state;
   logic reg_en, pwr_down, rx_take, tx_valid, tx_end, reg_wr, reg_rd;
   logic cmd_done, l_rx_valid, rxcmd_valid, l_rd_valid;
   logic [2:0] mode;
   logic [5:0] reg_addr;
   logic [7:0] tx_data, reg_wdata, l_rx_data, rxcmd, l_rd_data;
   logic [15:0] wr_v, rd_v, tx_v, end_n, rx_v, rxc_v, rdv_v;
   int fails, checks_done, n;

   upc_if upc_if_inst ();
   upc_phy upc_phy_inst (.SYS_CLK(sys_clk), .RST_N(rst_n), .CHIP_SEL(chip_sel), .CHIP_SEL_N(chip_sel_n),
      .VIO_OK(vio_ok), .VCORE_OK(vcore_ok), .CRYSTAL_INPUT_OK(xtal_ok), .MODE_SEL(mode_sel),
      .RX_VALID(p_rx_valid), .RX_DATA(p_rx_data), .STATUS(status), .REG_RD_DATA(p_rd_data),
      .LINE_STATE(line_state), .REG_EN(reg_en), .PWR_DOWN(pwr_down), .MODE(mode), .RX_TAKE(rx_take),
      .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_END(tx_end), .REG_WR(reg_wr), .REG_RD(reg_rd),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .ULPI(upc_if_inst));
   upc_link upc_link_inst (.SYS_CLK(sys_clk), .RST_N(rst_n), .CMD_VALID(cmd_valid), .CMD_BYTE(cmd_byte),
      .CMD_DATA(cmd_data), .ABORT(abort), .WAKE(wake), .CMD_DONE(cmd_done), .RX_VALID(l_rx_valid),
      .RX_DATA(l_rx_data), .RXCMD_VALID(rxcmd_valid), .RXCMD(rxcmd), .REG_RD_VALID(l_rd_valid),
      .REG_RD_DATA(l_rd_data), .ULPI(upc_if_inst));
   upc_props upc_props_inst (.SYS_CLK(sys_clk), .RST_N(rst_n), .CHIP_SEL(chip_sel), .CHIP_SEL_N(chip_sel_n),
      .clk_w(upc_if_inst.clk_w), .clk_oe(upc_if_inst.clk_oe), .dir_w(upc_if_inst.dir_w),
      .dir_oe(upc_if_inst.dir_oe), .nxt_w(upc_if_inst.nxt_w), .nxt_oe(upc_if_inst.nxt_oe),
      .phy_d_oe(upc_if_inst.phy_d_oe), .link_d_oe(upc_if_inst.link_d_oe), .stp(upc_if_inst.stp),
      .data_w(upc_if_inst.data_w));

   always #20 sys_clk = ~sys_clk;

   // last value of each one-cycle pulse, count of tx_end pulses
   always @(posedge sys_clk) begin
      if (reg_wr === 1'b1) wr_v <= {2'h0, reg_addr, reg_wdata};
      if (reg_rd === 1'b1) rd_v <= {10'h000, reg_addr};
      if (tx_valid === 1'b1) tx_v <= {8'h00, tx_data};
      if (tx_end === 1'b1) end_n <= end_n + 16'h0001;
      if (l_rx_valid === 1'b1) rx_v <= {8'h00, l_rx_data};
      if (rxcmd_valid === 1'b1) rxc_v <= {8'h00, rxcmd};
      if (l_rd_valid === 1'b1) rdv_v <= {8'h00, l_rd_data};
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic step(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask : step

   task automatic wait_dir(input logic v, input int lim);
      n = 0;
      while (upc_if_inst.dir_w !== v && n < lim) begin
         step(1);
         n++;
      end
   endtask : wait_dir

   task automatic wait_ready();
      n = 0;
      while ((n < 40 || upc_if_inst.dir_w !== 1'b0 || mode !== UPC_M_SYNC || pwr_down !== 1'b0) && n < 400) begin
         step(1);
         n++;
      end
      check("ready", {15'h0000, n < 400}, 16'h0001);
   endtask : wait_ready

   task automatic do_cmd(input logic [7:0] b, input logic [7:0] d);
      {wr_v, rd_v, tx_v, rdv_v, end_n} = {{4{16'hFFFF}}, 16'h0000};
      cmd_byte = b;
      cmd_data = d;
      cmd_valid = 1'b1;
      n = 0;
      while (cmd_done !== 1'b1 && n < 200) begin
         step(1);
         n++;
      end
      cmd_valid = 1'b0;
      step(12);
      check("cmd_done", {15'h0000, n < 200}, 16'h0001);
   endtask : do_cmd

   task automatic t_start();
      int k;
      wait_ready();
      check("pwr_down", {15'h0000, pwr_down}, 16'h0000);
      k = 0;
      repeat (8) begin
         step(1);
         k += upc_if_inst.clk_w;
      end
      check("clk_high", k[15:0], 16'h0004);
   endtask : t_start

   task automatic t_regs();
      do_cmd({2'h2, 6'h15}, 8'h5A);
      check("reg_write", wr_v, 16'h155A);
      p_rd_data = 8'hC3;
      do_cmd({2'h3, 6'h2A}, 8'h00);
      check("reg_read_addr", rd_v, 16'h002A);
      check("reg_read_data", rdv_v, 16'h00C3);
      do_cmd({2'h1, 6'h01}, 8'h3C);
      check("tx_byte", tx_v, 16'h003C);
      check("tx_end", end_n, 16'h0001);
   endtask : t_regs

   task automatic t_rx_abort();
      rxc_v = 16'hFFFF;
      rx_v = 16'hFFFF;
      line_state = 2'h2;
      step(40);
      check("rxcmd_line", rxc_v & 16'h0003, 16'h0002);
      p_rx_data = 8'hA5;
      p_rx_valid = 1'b1;
      step(40);
      check("rx_byte", rx_v, 16'h00A5);
      abort = 1'b1;
      wait_dir(1'b0, 24);
      abort = 1'b0;
      p_rx_valid = 1'b0;
      check("abort_dir", {15'h0000, upc_if_inst.dir_w}, 16'h0000);
      wait_ready();
   endtask : t_rx_abort

   task automatic t_modes();
      int k;
      for (k = 1; k < 5; k++) begin
         mode_sel = 5'h01 << k;
         step(40);
         check("mode", {13'h0000, mode}, k[15:0]);
         check("mode_dir", {15'h0000, upc_if_inst.dir_w}, 16'h0001);
         mode_sel = 5'h01;
         wake = 1'b1;
         step(8);
         wake = 1'b0;
         wait_ready();
      end
      mode_sel = 5'h06;
      step(40);
      check("two_modes", {13'h0000, mode}, 16'h0000);
      mode_sel = 5'h01;
   endtask : t_modes

   task automatic t_power();
      int k;
      for (k = 0; k < 3; k++) begin
         chip_sel = (k != 0);
         vcore_ok = (k != 0);
         chip_sel_n = (k == 1);
         vio_ok = (k != 2);
         step(14);
         check("pwr_down", {15'h0000, pwr_down}, 16'h0001);
         check("pin_oe", {upc_if_inst.phy_d_oe, 5'h00, upc_if_inst.clk_oe, upc_if_inst.dir_oe,
            upc_if_inst.nxt_oe}, 16'h0000);
         {chip_sel, chip_sel_n, vio_ok, vcore_ok} = 4'hB;
         wait_dir(1'b1, 60);
         check("restart_dir", {15'h0000, upc_if_inst.dir_w}, 16'h0001);
         wait_ready();
      end
   endtask : t_power

   task automatic summarize();
      if (fails == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : summarize

   initial begin
      sys_clk = 1'b0;
      rst_n = 1'b0;
      {chip_sel, chip_sel_n, vio_ok, vcore_ok, xtal_ok} = 5'h17;
      mode_sel = 5'h01;
      {p_rx_valid, cmd_valid, abort, wake} = 4'h0;
      {p_rx_data, status, p_rd_data, cmd_byte, cmd_data} = 40'h0000000000;
      line_state = 2'h0;
      fails = 0;
      checks_done = 0;
      step(2);
      rst_n = 1'b1;
      t_start();
      t_regs();
      t_rx_abort();
      t_modes();
      t_power();
      summarize();
   end

   // cuts a hang well past the expected run length
   initial begin
      #200000;
      fails++;
      summarize();
   end
endmodule : upc_tb_top
